// ==== verilog/sdg_spi_datagram_slave.sv ====
// Purpose: serial datagram slave, 40-bit exchanges with a host
// Assumes: serial clock idle high, high phase over 4 mclk; a quarter of mclk gives only 2
// Notes: commands leave through a two-entry buffer; reads answered via rsp port
`timescale 1ns/100ps
module sdg_spi_datagram_slave (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic chip_select_n,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  input wire logic [7:0] status_events,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic cmd_write,
  output logic [6:0] cmd_addr,
  output logic [31:0] cmd_data,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_data,
  output logic cmd_overrun
);
  // synchronisers: stage 1 read only by stage 2
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic sck_s1_q, sck_s2_q, sck_s3_q;
  logic sdi_s1_q, sdi_s2_q;
  logic [5:0] cnt_q;
  logic [39:0] shift_q;
  logic [31:0] reply_q;
  logic out_bit_q;
  logic overrun_q;
  logic sdo_link_q;

  sdg_stream_if push_if ();
  sdg_stream_if pop_if ();

  // edges seen between the last two stages, never on the metastable first one
  function automatic logic edge_rose(input logic older, input logic newer);
    return ~older & newer;
  endfunction

  function automatic logic edge_fell(input logic older, input logic newer);
    return older & ~newer;
  endfunction

  wire cs_fall = edge_fell(cs_s3_q, cs_s2_q);
  wire cs_rise = edge_rose(cs_s3_q, cs_s2_q);
  wire sck_rise = edge_rose(sck_s3_q, sck_s2_q);
  wire frame_on = ~cs_s2_q;
  wire cnt_full = (cnt_q == sdg_pkg::CNT_FULL);
  wire exec = cs_rise & cnt_full;
  wire is_write = shift_q[sdg_pkg::WR_BIT];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      sck_s1_q <= 1'b1;
      sck_s2_q <= 1'b1;
      sck_s3_q <= 1'b1;
      sdi_s1_q <= 1'b0;
      sdi_s2_q <= 1'b0;
    end else begin
      cs_s1_q <= chip_select_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      sck_s1_q <= serial_clock_in;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      sdi_s1_q <= serial_data_in;
      sdi_s2_q <= sdi_s1_q;
    end
  end

  // bit counter saturates at 40: only "40 or more" matters
  always_ff @(posedge mclk) begin
    if (!rst_n || cs_fall) begin
      cnt_q <= '0;
    end else if (frame_on && sck_rise && !cnt_full) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  // one register serves as reply, receive and 40-bit daisy-chain delay
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      shift_q <= '0;
    end else if (cs_fall) begin
      shift_q <= {status_events, reply_q};
    end else if (frame_on && sck_rise) begin
      shift_q <= {shift_q[38:0], sdi_s2_q};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      out_bit_q <= 1'b0;
    end else begin
      out_bit_q <= (cs_fall) ? status_events[7] : shift_q[sdg_pkg::WR_BIT];
    end
  end

  // reply for the next datagram
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reply_q <= sdg_pkg::REPLY_RST;
    end else if (exec && is_write) begin
      reply_q <= shift_q[sdg_pkg::DATA_MSB:0];
    end else if (rsp_valid) begin
      reply_q <= rsp_data;
    end
  end

  // host cannot be stalled, so a full buffer drops the command and flags it
  assign push_if.valid = exec;
  assign push_if.data = shift_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      overrun_q <= 1'b0;
    end else begin
      overrun_q <= exec & ~push_if.ready;
    end
  end

  sdg_fifo2 u_buf (
    .clk(mclk),
    .rst_n(rst_n),
    .in_s(push_if),
    .out_s(pop_if)
  );

  assign cmd_valid = pop_if.valid;
  assign pop_if.ready = cmd_ready;
  assign cmd_write = pop_if.data[sdg_pkg::WR_BIT];
  assign cmd_addr = pop_if.data[sdg_pkg::ADDR_MSB:sdg_pkg::ADDR_LSB];
  assign cmd_data = pop_if.data[sdg_pkg::DATA_MSB:0];
  assign cmd_overrun = overrun_q;

  // link domain: out_bit_q settles 3 to 4 mclk after the serial rising edge, so the falling
  // edge samples it stably only with a high phase over 4 mclk, not the 2 mclk of the quarter-rate limit
  always_ff @(negedge serial_clock_in) begin
    sdo_link_q <= out_bit_q;
  end

  assign serial_data_out_oe = frame_on;
  assign serial_data_out = sdo_link_q & frame_on;
endmodule // sdg_spi_datagram_slave

// ==== verilog/sdg_pkg.sv ====
// Purpose: constants for the serial datagram slave
// Assumes: 40-bit datagrams, msb first, serial clock idle high
// Notes: How it works list below
// How it works
// - every transfer shifts out the eight selected event bits first.
// - transfers with fewer than 40 serial clocks are dropped, reads included.
// - an eight-clock transfer still yields the whole status byte.
// - clocks beyond 40 return input bits on the output 40 clocks later.
// - chip select rising after 40 clocks copies the shift register into the two-entry command buffer, unless it is full.
// - with over 40 bits, only the last 40 form the command.
// - pins are sampled on the system clock; serial clock at most a quarter. The output needs a high phase over 4 mclk.
// - datagram is address byte plus four data bytes, msb first.
// - address msb set means write, clear means read with dummy data.
// - next datagram returns read data, or the previous write data.
// - input captured on serial rising edge, output changes after falling edge.
package sdg_pkg;
  localparam int unsigned DG_BITS = 40;
  localparam int unsigned CNT_W = 6;
  localparam logic [5:0] CNT_FULL = 6'h28;
  localparam int unsigned WR_BIT = 39;
  localparam int unsigned ADDR_MSB = 38;
  localparam int unsigned ADDR_LSB = 32;
  localparam int unsigned STAT_LSB = 32;
  localparam int unsigned DATA_MSB = 31;
  localparam logic [31:0] REPLY_RST = 32'h0000_0000;
  localparam int unsigned FIFO_DEPTH = 2;
endpackage

// ==== verilog/sdg_stream_if.sv ====
// Purpose: valid/ready carrier for received commands
// Assumes: single clock, transfer when valid and ready both high
// Notes: data is the full 40-bit datagram
`timescale 1ns/100ps
interface sdg_stream_if;
  logic valid;
  logic ready;
  logic [39:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // sdg_stream_if

// ==== verilog/sdg_fifo2.sv ====
// Purpose: two-entry command buffer
// Assumes: synchronous active-low reset
// Notes: output data read from storage registers
`timescale 1ns/100ps
module sdg_fifo2 (
  input wire logic clk,
  input wire logic rst_n,
  sdg_stream_if.snk in_s,
  sdg_stream_if.src out_s
);
  logic [39:0] mem_q [sdg_pkg::FIFO_DEPTH];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  wire push = in_s.valid & in_s.ready;
  wire pop = out_s.valid & out_s.ready;

  assign in_s.ready = (cnt_q != 2'h2);
  assign out_s.valid = (cnt_q != 2'h0);
  assign out_s.data = mem_q[rd_ptr_q];
  assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_s.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wr_ptr_q <= wr_ptr_q ^ push;
      rd_ptr_q <= rd_ptr_q ^ pop;
      cnt_q <= cnt_d;
    end
  end
endmodule // sdg_fifo2

// ==== testbench/sdg_chk.sv ====
// Purpose: port checker for the datagram slave
// Assumes: pins reach the core within 3 mclk
// Notes: bound below
`timescale 1ns/100ps
module sdg_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic chip_select_n,
  input wire logic serial_clock_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  input wire logic cmd_valid,
  input wire logic cmd_overrun
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_OE_ON: assert property (!chip_select_n [*5] |-> serial_data_out_oe) else $error("oe off");
  AST_OE_OFF: assert property (chip_select_n [*5] |-> !serial_data_out_oe) else $error("oe on");
  AST_OE_LAG: assert property ($rose(serial_data_out_oe) |-> !$past(chip_select_n, 2)) else $error("oe");
  AST_IDLE: assert property (!serial_data_out_oe |-> !serial_data_out) else $error("sdo idle");
  AST_SDO: assert property (serial_data_out_oe && $past(serial_data_out_oe) && $changed(serial_data_out)
    |-> !serial_clock_in) else $error("sdo edge");
  AST_EXEC: assert property ($rose(cmd_valid) |-> chip_select_n && $past(chip_select_n, 3)) else $error("early");
  AST_QUIET: assert property (!chip_select_n [*2] |-> !$rose(cmd_valid)) else $error("cmd in frame");
  AST_OVR: assert property (cmd_overrun |-> $past(cmd_valid) ##1 !cmd_overrun) else $error("overrun");
endmodule // sdg_chk
bind sdg_spi_datagram_slave sdg_chk u_chk (.mclk, .rst_n, .chip_select_n, .serial_clock_in, .serial_data_out,
  .serial_data_out_oe, .cmd_valid, .cmd_overrun);

// ==== testbench/sdg_host.sv ====
// Purpose: host master model
// Assumes: 125 ns serial clock, idle high, msb first
// Notes: released data line shows its inverse
`timescale 1ns/100ps
module sdg_host (
  output logic sck,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  initial {sck, cs_n, sdi} = 3'b110;
  // odd offset keeps serial edges off mclk edges
  task automatic xfer(input int n, input logic [79:0] d, output logic [79:0] r);
    r = 80'h0;
    #201.3 cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #62.5 sck = 1'b0;
      sdi = d[i];
      #62.5 sck = 1'b1;
      r = {r[78:0], sdo};
    end
    #20 cs_n = 1'b1;
    sdi = ~sdi;
  endtask
endmodule // sdg_host

// ==== testbench/testbench.sv ====
// Purpose: bench for the datagram slave
// Assumes: host model owns the link pins
// Notes: commands drained by hand
`timescale 1ns/100ps
module testbench;
  logic mclk = 1'b0, rst_n = 1'b0, cmd_ready = 1'b0, rsp_valid = 1'b0, ovr = 1'b0;
  logic chip_select_n, serial_clock_in, serial_data_in, serial_data_out, serial_data_out_oe;
  logic cmd_valid, cmd_write, cmd_overrun;
  logic [7:0] status_events = 8'h3c;
  logic [6:0] cmd_addr;
  logic [31:0] cmd_data, rsp_data = 32'h0;
  logic [79:0] r;
  int errors = 0, total_checks = 0;
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (cmd_overrun === 1'b1) ovr <= 1'b1;
  sdg_spi_datagram_slave u_dut (.mclk, .rst_n, .chip_select_n, .serial_clock_in, .serial_data_in, .serial_data_out,
    .serial_data_out_oe, .status_events, .cmd_valid, .cmd_ready, .cmd_write, .cmd_addr, .cmd_data, .rsp_valid,
    .rsp_data, .cmd_overrun);
  sdg_host u_host (.sck(serial_clock_in), .cs_n(chip_select_n), .sdi(serial_data_in), .sdo(serial_data_out));
  task automatic chk(input string nm, input logic [79:0] s, input logic [79:0] e);
    total_checks++;
    if (s !== e) errors++;
    if (s !== e) $display("mismatch %s exp %h seen %h", nm, e, s);
  endtask
  task automatic pop(input logic [39:0] e);
    // step off the edge that may just have popped the previous entry
    @(negedge mclk);
    repeat (20) if (cmd_valid !== 1'b1) @(negedge mclk);
    chk("cmd", {39'h0, cmd_valid, cmd_write, cmd_addr, cmd_data}, {39'h0, 1'b1, e});
    @(posedge mclk) cmd_ready <= 1'b1;
    @(posedge mclk) cmd_ready <= 1'b0;
  endtask
  task t_frames;
    u_host.xfer(40, 80'h951234abcd, r);
    chk("wr", r, {40'h0, 8'h3c, sdg_pkg::REPLY_RST});
    pop(40'h951234abcd);
    u_host.xfer(8, 80'hda, r);
    chk("short", r, {72'h0, 8'h3c});
    u_host.xfer(48, 80'h710a87654321, r);
    chk("chain", r, {32'h0, 8'h3c, 32'h1234abcd, 8'h71});
    pop(40'h0a87654321);
    @(posedge mclk) rsp_valid <= 1'b1;
    rsp_data <= 32'h0f1e2d3c;
    status_events <= 8'ha5;
    @(posedge mclk) rsp_valid <= 1'b0;
    u_host.xfer(40, 80'h0b00000000, r);
    chk("rd", r, {40'h0, 8'ha5, 32'h0f1e2d3c});
    pop(40'h0b00000000);
    $display("frames done");
  endtask
  task t_full;
    for (int i = 0; i < 3; i++) u_host.xfer(40, {48'h90, 24'h0, i[7:0]}, r);
    repeat (10) @(negedge mclk);
    chk("ovr", {79'h0, ovr}, 80'h1);
    pop(40'h9000000000);
    pop(40'h9000000001);
    @(negedge mclk);
    chk("empty", {79'h0, cmd_valid}, 80'h0);
    $display("full done");
  endtask
  task t_reset;
    u_host.xfer(40, 80'hc4deadbeef, r);
    repeat (10) @(negedge mclk);
    chk("held", {79'h0, cmd_valid}, 80'h1);
    @(posedge mclk) rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk("rst", {77'h0, cmd_valid, cmd_overrun, serial_data_out_oe}, 80'h0);
    u_host.xfer(40, 80'h2100000000, r);
    chk("rst rd", r, {40'h0, 8'ha5, sdg_pkg::REPLY_RST});
    pop(40'h2100000000);
    // a read carries dummy data, so the reply must not pick it up
    u_host.xfer(40, 80'h2200000000, r);
    chk("rd keep", r, {40'h0, 8'ha5, sdg_pkg::REPLY_RST});
    pop(40'h2200000000);
    $display("reset done");
  endtask
  task results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    results;
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    t_frames;
    t_full;
    t_reset;
    results;
  end
endmodule // testbench
